//--- rtl/dcd_top.sv
// Dual main datapath with six channelizers, lane crossbar and serial control port
// Notes on behaviour
// - Six channelizers, three summed into each of two main datapaths.
// - Unused channelizers can be switched off through the channel enable bits; a disabled one outputs zero.
// - Interpolating channels get their own gain and NCO; bypass skips both.
// - One interpolation code serves all channels; mixed factors are impossible.
// - Channel interpolation: 1x, 2x, 3x, 4x, 6x or 8x.
// - Main interpolation: 1x, 2x, 4x, 6x, 8x or 12x.
// - Both main interpolators share one setting.
// - Each group sum feeds its own main datapath.
// - Optional PA protection ramps gain down to mute before harm.
// - Each main datapath has its own programmable, optional main NCO.
// - NCOs offer a 48-bit modulus wrap for fractional frequency steps.
// - Main NCO has four output switch modes and a calibration tone.
// - Tone mode: channel level from link data or one shared register; the main path always sends the shared register level; own frequency.
// - Page bit 2 of 0x300 shows link 1 lanes as logical lanes plus four.
// - Logical lanes come from physical lanes through the crossbar at 0x308.
// - One to eight lanes per link; four at most per link when dual.
// - Alignment pulse resets interpolation phase and NCOs for fixed latency.
`timescale 1ns/1ps
`default_nettype none
module dcd_top import dcd_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Serial control port
  input wire logic spi_sclk,
  input wire logic spi_csb,
  input wire logic spi_sdi,
  output logic spi_sdo,
  output logic spi_sdo_oe,
  // Lane data from the link layer
  input wire dcd_iq_t [NUM_LANE-1:0] phys_lane,
  input wire logic [NUM_LANE-1:0] lane_valid,
  output logic sample_take,
  // Alignment pin
  input wire logic sysref,
  // Converter samples
  output logic signed [15:0] dac0,
  output logic signed [15:0] dac1,
  output logic [1:0] pa_mute
);
  // Control registers
  logic [7:0] link_page_select;
  logic [2:0] xbar [NUM_LANE];
  logic [NUM_CH-1:0] chan_en;
  logic [2:0] ch_interp;
  logic [2:0] main_interp;
  logic [2:0] ch_page;
  logic [15:0] ch_gain [NUM_CH];
  logic [47:0] ch_ftw [NUM_CH];
  logic [5:0] nco_ctrl;
  logic [15:0] dds_lvl;
  logic [47:0] modulus;
  logic main_page;
  logic [47:0] main_ftw [2];
  logic pa_en;
  logic [7:0] pa_thr;
  logic sysref_seen;

  // Serial port state
  logic [2:0] sclk_s;
  logic [1:0] csb_s;
  logic [1:0] sdi_s;
  logic [4:0] bitcnt;
  logic [15:0] sh;
  logic rw;
  logic [14:0] addr;
  logic [7:0] rd_sh;
  logic wr_en;
  logic [7:0] wr_data;
  logic [7:0] rd_data;
  wire sclk_rise = sclk_s[1] & ~sclk_s[2];
  wire sclk_fall = ~sclk_s[1] & sclk_s[2];

  // Pins pass two flops first; the serial clock gets a third for edge detection
  always_ff @(posedge clk_sys) begin
    sclk_s <= {sclk_s[1:0], spi_sclk};
    csb_s <= {csb_s[0], spi_csb};
    sdi_s <= {sdi_s[0], spi_sdi};
  end

  // Frame: R/W bit, 15-bit address, 8 data bits, MSB first
  always_ff @(posedge clk_sys) begin
    wr_en <= 1'b0;
    if (srst || csb_s[1]) begin
      bitcnt <= 5'd0;
      spi_sdo_oe <= 1'b0;
      spi_sdo <= 1'b0;
      if (srst) begin
        rw <= 1'b0;
        addr <= 15'h0;
        sh <= 16'h0;
        rd_sh <= 8'h0;
        wr_data <= 8'h0;
      end
    end else if (sclk_rise && bitcnt < SPI_FRAME_BITS) begin
      sh <= {sh[14:0], sdi_s[1]};
      bitcnt <= bitcnt + 5'd1;
      if (bitcnt == SPI_ADDR_BITS - 5'd1) begin
        rw <= sh[14];
        addr <= {sh[13:0], sdi_s[1]};
      end
      if (bitcnt == SPI_FRAME_BITS - 5'd1 && !rw) begin
        wr_en <= 1'b1;
        wr_data <= {sh[6:0], sdi_s[1]};
      end
    end else if (sclk_fall && rw && bitcnt >= SPI_ADDR_BITS) begin
      spi_sdo_oe <= 1'b1;
      spi_sdo <= (bitcnt == SPI_ADDR_BITS) ? rd_data[7] : rd_sh[7];
      rd_sh <= (bitcnt == SPI_ADDR_BITS) ? {rd_data[6:0], 1'b0} : {rd_sh[6:0], 1'b0};
    end
  end

  // Crossbar and link paging
  dcd_iq_t [NUM_LANE-1:0] log_lane;
  logic [NUM_LANE-1:0] log_valid;
  for (genvar l = 0; l < NUM_LANE; l++) begin : g_xbar
    assign log_lane[l] = phys_lane[xbar[l]];
    assign log_valid[l] = lane_valid[xbar[l]];
  end
  // Link 1 lanes sit four above link 0 in logical numbering
  wire [3:0] link_lane_valid = link_page_select[LP_PAGE] ? log_valid[7:4] : log_valid[3:0];

  // Alignment edge from the synchronised pin; declared early since the register block reads it
  logic [2:0] sysref_s;
  always_ff @(posedge clk_sys) begin
    sysref_s <= {sysref_s[1:0], sysref};
  end
  wire align = sysref_s[1] & ~sysref_s[2];

  // Field offsets within multi-byte registers
  wire [14:0] gain_off = wr_addr_off(addr, ADDR_CH_GAIN);
  wire [14:0] ftw_off = wr_addr_off(addr, ADDR_CH_FTW);
  wire [14:0] mod_off = wr_addr_off(addr, ADDR_MODULUS);
  wire [14:0] mftw_off = wr_addr_off(addr, ADDR_MAIN_FTW);
  wire [14:0] xb_off = wr_addr_off(addr, ADDR_XBAR);
  wire [14:0] lvl_off = wr_addr_off(addr, ADDR_DDS_LVL);
  wire ch_ok = ch_page < 3'(NUM_CH);

  function automatic logic [14:0] wr_addr_off(input logic [14:0] a, input logic [14:0] base);
    wr_addr_off = a - base;
  endfunction : wr_addr_off

  // Register writes; the alignment flag sets over a clear in the same cycle
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      link_page_select <= 8'h00;
      for (int l = 0; l < NUM_LANE; l++) xbar[l] <= 3'(l);
      chan_en <= '0;
      ch_interp <= 3'd0;
      main_interp <= 3'd0;
      ch_page <= 3'd0;
      for (int c = 0; c < NUM_CH; c++) begin
        ch_gain[c] <= GAIN_RST;
        ch_ftw[c] <= 48'h0;
      end
      nco_ctrl <= 6'h00;
      dds_lvl <= 16'h0000;
      modulus <= MOD_RST;
      main_page <= 1'b0;
      main_ftw[0] <= 48'h0;
      main_ftw[1] <= 48'h0;
      pa_en <= 1'b0;
      pa_thr <= PA_THR_RST;
      sysref_seen <= 1'b0;
    end else begin
      if (wr_en) begin
        if (addr == ADDR_LINK_PAGE) link_page_select <= wr_data;
        if (xb_off < 15'd4) begin
          xbar[2 * xb_off[1:0]] <= wr_data[2:0];
          xbar[2 * xb_off[1:0] + 1] <= wr_data[6:4];
        end
        if (addr == ADDR_CHAN_EN) chan_en <= wr_data[5:0];
        if (addr == ADDR_CH_INTERP) ch_interp <= wr_data[2:0];
        if (addr == ADDR_MAIN_INTERP) main_interp <= wr_data[2:0];
        if (addr == ADDR_CH_PAGE) ch_page <= wr_data[2:0];
        if (gain_off < 15'd2 && ch_ok) ch_gain[ch_page][8 * gain_off[0] +: 8] <= wr_data;
        if (ftw_off < 15'd6 && ch_ok) ch_ftw[ch_page][8 * ftw_off[2:0] +: 8] <= wr_data;
        if (addr == ADDR_NCO_CTRL) nco_ctrl <= wr_data[5:0];
        if (lvl_off < 15'd2) dds_lvl[8 * lvl_off[0] +: 8] <= wr_data;
        if (mod_off < 15'd6) modulus[8 * mod_off[2:0] +: 8] <= wr_data;
        if (addr == ADDR_MAIN_PAGE) main_page <= wr_data[0];
        if (mftw_off < 15'd6) main_ftw[main_page][8 * mftw_off[2:0] +: 8] <= wr_data;
        if (addr == ADDR_PA_CTRL) pa_en <= wr_data[0];
        if (addr == ADDR_PA_THR) pa_thr <= wr_data;
        if (addr == ADDR_STATUS && wr_data[ST_SYSREF]) sysref_seen <= 1'b0;
      end
      if (align) sysref_seen <= 1'b1;
    end
  end

  // Read decode
  wire [3:0] ch_fac = dcd_ch_fac(ch_interp);
  wire [3:0] main_fac = dcd_main_fac(main_interp);
  wire cfg_err = (ch_fac == 4'd0) || (main_fac == 4'd0);
  always_comb begin
    rd_data = 8'h00;
    if (addr == ADDR_LINK_PAGE) rd_data = link_page_select;
    if (addr == ADDR_LANE_STAT) rd_data = {4'h0, link_lane_valid};
    if (xb_off < 15'd4) rd_data = {1'b0, xbar[2 * xb_off[1:0] + 1], 1'b0, xbar[2 * xb_off[1:0]]};
    if (addr == ADDR_CHAN_EN) rd_data = {2'b00, chan_en};
    if (addr == ADDR_CH_INTERP) rd_data = {5'h00, ch_interp};
    if (addr == ADDR_MAIN_INTERP) rd_data = {5'h00, main_interp};
    if (addr == ADDR_CH_PAGE) rd_data = {5'h00, ch_page};
    if (gain_off < 15'd2 && ch_ok) rd_data = ch_gain[ch_page][8 * gain_off[0] +: 8];
    if (ftw_off < 15'd6 && ch_ok) rd_data = ch_ftw[ch_page][8 * ftw_off[2:0] +: 8];
    if (addr == ADDR_NCO_CTRL) rd_data = {2'b00, nco_ctrl};
    if (lvl_off < 15'd2) rd_data = dds_lvl[8 * lvl_off[0] +: 8];
    if (mod_off < 15'd6) rd_data = modulus[8 * mod_off[2:0] +: 8];
    if (addr == ADDR_MAIN_PAGE) rd_data = {7'h00, main_page};
    if (mftw_off < 15'd6) rd_data = main_ftw[main_page][8 * mftw_off[2:0] +: 8];
    if (addr == ADDR_PA_CTRL) rd_data = {7'h00, pa_en};
    if (addr == ADDR_PA_THR) rd_data = pa_thr;
    if (addr == ADDR_STATUS) rd_data = {4'h0, cfg_err, sysref_seen, pa_mute};
  end

  // Interpolation timing: one shared main count, one shared channel count
  logic [3:0] main_cnt;
  logic [3:0] ch_cnt;
  logic main_step;
  wire main_tick = (main_cnt == 4'd0);
  wire ch_tick = main_tick && (ch_cnt == 4'd0);
  always_ff @(posedge clk_sys) begin
    if (srst || align || cfg_err) begin
      main_cnt <= 4'd0;
      ch_cnt <= 4'd0;
      main_step <= 1'b0;
      sample_take <= 1'b0;
    end else begin
      main_cnt <= main_tick ? main_fac - 4'd1 : main_cnt - 4'd1;
      if (main_tick) ch_cnt <= (ch_cnt == 4'd0) ? ch_fac - 4'd1 : ch_cnt - 4'd1;
      main_step <= main_tick;
      sample_take <= ch_tick;
    end
  end

  // Six channelizers; group 0 reads logical lanes 0-2, group 1 lanes 4-6
  dcd_iq_t ch_out [NUM_CH];
  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    dcd_channel u_ch (
      .clk_sys(clk_sys),
      .srst(srst),
      .take(sample_take),
      .step(main_step),
      .align(align),
      .enable(chan_en[c]),
      .bypass(ch_interp == 3'd0),
      .gain(ch_gain[c]),
      .ftw(ch_ftw[c]),
      .modulus(modulus),
      .mod_en(nco_ctrl[NC_MOD_EN]),
      .dds(nco_ctrl[NC_DDS]),
      .level(nco_ctrl[NC_LVL_REG] ? dds_lvl : log_lane[c + c / 3].i),
      .in_iq(log_lane[c + c / 3]),
      .out_iq(ch_out[c])
    );
  end

  // Main datapaths: sum, hold, NCO, PA ramp
  logic [47:0] main_acc [2];
  dcd_iq_t main_in [2];
  dcd_iq_t main_mix [2];
  dcd_iq_t main_out [2];
  logic [7:0] ramp [2];
  for (genvar m = 0; m < 2; m++) begin : g_main
    wire signed [17:0] sum_i = 18'(ch_out[3 * m].i) + 18'(ch_out[3 * m + 1].i) + 18'(ch_out[3 * m + 2].i);
    wire signed [17:0] sum_q = 18'(ch_out[3 * m].q) + 18'(ch_out[3 * m + 1].q) + 18'(ch_out[3 * m + 2].q);
    // Calibration tone and tone mode both feed a fixed level into the NCO
    wire tone = nco_ctrl[NC_CAL] | nco_ctrl[NC_DDS];
    wire dcd_iq_t sum_sat = '{i: dcd_sat(sum_i), q: dcd_sat(sum_q)};
    wire dcd_iq_t src = tone ? dcd_iq_t'{i: dds_lvl, q: 16'h0000} : sum_sat;
    wire [15:0] mag = main_in[m].i[15] ? 16'(-main_in[m].i) : main_in[m].i;
    // Protection looks at the sum before the NCO so muting starts early
    wire over = pa_en && (mag[15:8] > pa_thr);

    always_ff @(posedge clk_sys) begin
      if (srst) main_in[m] <= '0;
      else if (main_step) main_in[m] <= src;
    end

    // A zero frequency word leaves the main NCO as a pass-through
    always_ff @(posedge clk_sys) begin
      if (srst || align) main_acc[m] <= 48'h0;
      else main_acc[m] <= dcd_nco(main_acc[m], main_ftw[m], modulus, nco_ctrl[NC_MOD_EN]);
    end
    assign main_mix[m] = dcd_rot(main_in[m], main_acc[m][47:45]);

    // Ramp falls one step a cycle while over threshold, climbs back once clear
    always_ff @(posedge clk_sys) begin
      if (srst) begin
        ramp[m] <= RAMP_FULL;
        pa_mute[m] <= 1'b0;
        main_out[m] <= '0;
      end else begin
        if (over && ramp[m] != 8'h00) ramp[m] <= ramp[m] - 8'h01;
        else if (!over && ramp[m] != RAMP_FULL) ramp[m] <= ramp[m] + 8'h01;
        pa_mute[m] <= (ramp[m] == 8'h00);
        main_out[m] <= '{i: dcd_scale(main_mix[m].i, {7'h00, ramp[m], 1'b0} << 6),
                         q: dcd_scale(main_mix[m].q, {7'h00, ramp[m], 1'b0} << 6)};
      end
    end
  end

  // Modulator switch decides which component reaches each converter
  dcd_sw_t sw;
  assign sw = dcd_sw_t'(nco_ctrl[NC_SW_LO +: 2]);
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      dac0 <= 16'h0000;
      dac1 <= 16'h0000;
    end else begin
      unique case (sw)
        SW_DAC_I: begin
          dac0 <= main_out[0].i;
          dac1 <= main_out[1].i;
        end
        SW_DAC_Q: begin
          dac0 <= main_out[0].q;
          dac1 <= main_out[1].q;
        end
        SW_IF_PAIR: begin
          dac0 <= main_out[0].i;
          dac1 <= main_out[0].q;
        end
        SW_DAC_BOTH: begin
          dac0 <= main_out[0].i;
          dac1 <= main_out[0].i;
        end
      endcase
    end
  end
endmodule : dcd_top
`default_nettype wire

//--- common/dcd_pkg.sv
// Shared constants, types and arithmetic for the dual channelizer datapath
`default_nettype none
package dcd_pkg;
  // Register offsets
  localparam logic [14:0] ADDR_CHAN_EN = 15'h008;
  localparam logic [14:0] ADDR_CH_INTERP = 15'h010;
  localparam logic [14:0] ADDR_MAIN_INTERP = 15'h011;
  localparam logic [14:0] ADDR_CH_PAGE = 15'h020;
  localparam logic [14:0] ADDR_CH_GAIN = 15'h021;
  localparam logic [14:0] ADDR_CH_FTW = 15'h023;
  localparam logic [14:0] ADDR_NCO_CTRL = 15'h030;
  localparam logic [14:0] ADDR_DDS_LVL = 15'h031;
  localparam logic [14:0] ADDR_MODULUS = 15'h038;
  localparam logic [14:0] ADDR_MAIN_PAGE = 15'h040;
  localparam logic [14:0] ADDR_MAIN_FTW = 15'h041;
  localparam logic [14:0] ADDR_PA_CTRL = 15'h050;
  localparam logic [14:0] ADDR_PA_THR = 15'h051;
  localparam logic [14:0] ADDR_STATUS = 15'h060;
  localparam logic [14:0] ADDR_LINK_PAGE = 15'h300;
  localparam logic [14:0] ADDR_LANE_STAT = 15'h301;
  localparam logic [14:0] ADDR_XBAR = 15'h308;
  // Field positions
  localparam int NC_MOD_EN = 0;
  localparam int NC_DDS = 1;
  localparam int NC_LVL_REG = 2;
  localparam int NC_CAL = 3;
  localparam int NC_SW_LO = 4;
  localparam int LP_PAGE = 2;
  localparam int ST_SYSREF = 2;
  // Reset values
  localparam logic [15:0] GAIN_RST = 16'h4000;
  localparam logic [7:0] PA_THR_RST = 8'h7F;
  localparam logic [7:0] RAMP_FULL = 8'h80;
  localparam logic [47:0] MOD_RST = 48'h0;
  // Counts of frame bits, channels and lanes
  localparam logic [4:0] SPI_ADDR_BITS = 5'd16;
  localparam logic [4:0] SPI_FRAME_BITS = 5'd24;
  localparam int NUM_CH = 6;
  localparam int NUM_LANE = 8;

  typedef struct packed {
    logic signed [15:0] i;
    logic signed [15:0] q;
  } dcd_iq_t;

  typedef enum logic [1:0] {SW_DAC_I, SW_DAC_Q, SW_IF_PAIR, SW_DAC_BOTH} dcd_sw_t;

  // Eight-point sine table, full scale 16'h7FFF
  function automatic logic signed [15:0] dcd_sin(input logic [2:0] p);
    unique case (p)
      3'd0, 3'd4: dcd_sin = 16'h0000;
      3'd1, 3'd3: dcd_sin = 16'h5A82;
      3'd2: dcd_sin = 16'h7FFF;
      3'd5, 3'd7: dcd_sin = 16'hA57E;
      3'd6: dcd_sin = 16'h8001;
    endcase
  endfunction : dcd_sin

  // Complex rotation by the phase octant
  function automatic dcd_iq_t dcd_rot(input dcd_iq_t x, input logic [2:0] p);
    logic signed [31:0] c;
    logic signed [31:0] s;
    logic signed [32:0] ri;
    logic signed [32:0] rq;
    c = 32'(dcd_sin(p + 3'd2));
    s = 32'(dcd_sin(p));
    ri = 33'(x.i * c) - 33'(x.q * s);
    rq = 33'(x.i * s) + 33'(x.q * c);
    dcd_rot.i = ri[30:15];
    dcd_rot.q = rq[30:15];
  endfunction : dcd_rot

  // Gain with 16'h4000 as unity
  function automatic logic signed [15:0] dcd_scale(input logic signed [15:0] x, input logic signed [15:0] g);
    logic signed [31:0] m;
    m = x * g;
    dcd_scale = m[29:14];
  endfunction : dcd_scale

  function automatic logic signed [15:0] dcd_sat(input logic signed [17:0] v);
    if (v > 18'sh07FFF) dcd_sat = 16'h7FFF;
    else if (v < -18'sh08000) dcd_sat = 16'h8000;
    else dcd_sat = v[15:0];
  endfunction : dcd_sat

  // Accumulator step, wrapping at the modulus when enabled
  function automatic logic [47:0] dcd_nco(input logic [47:0] a, input logic [47:0] f, input logic [47:0] m,
                                          input logic me);
    logic [48:0] s;
    s = {1'b0, a} + {1'b0, f};
    if (me && m != MOD_RST && s >= {1'b0, m}) s = s - {1'b0, m};
    dcd_nco = s[47:0];
  endfunction : dcd_nco

  // Interpolation codes to factors; illegal codes give zero
  function automatic logic [3:0] dcd_ch_fac(input logic [2:0] c);
    unique case (c)
      3'd0: dcd_ch_fac = 4'd1;
      3'd1: dcd_ch_fac = 4'd2;
      3'd2: dcd_ch_fac = 4'd3;
      3'd3: dcd_ch_fac = 4'd4;
      3'd4: dcd_ch_fac = 4'd6;
      3'd5: dcd_ch_fac = 4'd8;
      default: dcd_ch_fac = 4'd0;
    endcase
  endfunction : dcd_ch_fac

  function automatic logic [3:0] dcd_main_fac(input logic [2:0] c);
    unique case (c)
      3'd0: dcd_main_fac = 4'd1;
      3'd1: dcd_main_fac = 4'd2;
      3'd2: dcd_main_fac = 4'd4;
      3'd3: dcd_main_fac = 4'd6;
      3'd4: dcd_main_fac = 4'd8;
      3'd5: dcd_main_fac = 4'd12;
      default: dcd_main_fac = 4'd0;
    endcase
  endfunction : dcd_main_fac
endpackage : dcd_pkg
`default_nettype wire

//--- rtl/dcd_channel.sv
// One complex channelizer: input hold, gain, channel NCO
`timescale 1ns/1ps
`default_nettype none
module dcd_channel import dcd_pkg::*; (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Timing
  input wire logic take,
  input wire logic step,
  input wire logic align,
  // Settings
  input wire logic enable,
  input wire logic bypass,
  input wire logic signed [15:0] gain,
  input wire logic [47:0] ftw,
  input wire logic [47:0] modulus,
  input wire logic mod_en,
  input wire logic dds,
  input wire logic signed [15:0] level,
  // Samples
  input wire dcd_iq_t in_iq,
  output dcd_iq_t out_iq
);
  logic [47:0] acc;
  dcd_iq_t held;
  dcd_iq_t src;
  dcd_iq_t gained;
  dcd_iq_t mixed;

  // Tone mode replaces the stream with a constant level on I
  assign src = dds ? dcd_iq_t'{i: level, q: 16'h0000} : held;
  assign gained = '{i: dcd_scale(src.i, gain), q: dcd_scale(src.q, gain)};
  assign mixed = dcd_rot(gained, acc[47:45]);

  // Hold the sample for the whole interpolation period
  always_ff @(posedge clk_sys) begin
    if (srst) held <= '0;
    else if (take) held <= in_iq;
  end

  // Phase advances once per channel output sample; alignment zeroes it
  always_ff @(posedge clk_sys) begin
    if (srst || align) acc <= 48'h0;
    else if (step && enable && !bypass) acc <= dcd_nco(acc, ftw, modulus, mod_en);
  end

  // Gain and NCO only act when interpolating; an idle channel adds nothing
  always_ff @(posedge clk_sys) begin
    if (srst || !enable) out_iq <= '0;
    else if (step) out_iq <= bypass ? src : mixed;
  end
endmodule : dcd_channel
`default_nettype wire

//--- tb/dcd_top_properties.sv
// Port-level assertions for the dual channelizer datapath
`timescale 1ns/1ps
`default_nettype none
module dcd_top_chk (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic srst,
  // Serial port
  input wire logic spi_sclk,
  input wire logic spi_csb,
  input wire logic spi_sdo,
  input wire logic spi_sdo_oe,
  // Datapath outputs
  input wire logic sample_take,
  input wire logic signed [15:0] dac0,
  input wire logic signed [15:0] dac1,
  input wire logic [1:0] pa_mute
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (srst);
  // Mute ages saturate at 7'h7F, long enough for any filter tail to drain
  logic [6:0] age0;
  logic [6:0] age1;
  always_ff @(posedge clk_sys) begin
    if (srst || !pa_mute[0]) age0 <= 7'h00;
    else if (age0 != 7'h7F) age0 <= age0 + 7'h01;
  end
  always_ff @(posedge clk_sys) begin
    if (srst || pa_mute != 2'b11) age1 <= 7'h00;
    else if (age1 != 7'h7F) age1 <= age1 + 7'h01;
  end
  AST_REL_DAC: assert property ($fell(srst) |-> dac0 == 16'h0000 && dac1 == 16'h0000)
    else $error("dac busy after reset");
  AST_REL_QUIET: assert property ($fell(srst) |-> pa_mute == 2'b00 && !sample_take && !spi_sdo_oe)
    else $error("flags busy after reset");
  AST_MUTE_DAC0: assert property (age0 == 7'h7F |-> dac0 == 16'h0000)
    else $error("dac0 live while muted");
  AST_MUTE_DAC1: assert property (age1 == 7'h7F |-> dac1 == 16'h0000)
    else $error("dac1 live while muted");
  AST_OE_IN_FRAME: assert property ($rose(spi_sdo_oe) |-> !spi_csb && $past(spi_csb, 8) == 1'b0)
    else $error("sdo enabled outside frame");
  AST_OE_HOLDS: assert property (spi_sdo_oe && !spi_csb |=> spi_sdo_oe)
    else $error("sdo dropped in frame");
  AST_OE_DROPS: assert property (spi_csb [*6] |-> !spi_sdo_oe)
    else $error("sdo left on after frame");
  AST_SDO_STABLE: assert property (spi_sclk [*6] ##0 spi_sdo_oe |-> $stable(spi_sdo))
    else $error("sdo moved while sclk high");
endmodule : dcd_top_chk
bind dcd_top dcd_top_chk dcd_top_chk_i (
  .clk_sys, .srst, .spi_sclk, .spi_csb, .spi_sdo, .spi_sdo_oe, .sample_take, .dac0, .dac1, .pa_mute
);
`default_nettype wire

//--- tb/dcd_lane_src.sv
// Link transmitter model feeding the physical lanes
`timescale 1ns/1ps
`default_nettype none
module dcd_lane_src import dcd_pkg::*; (
  // Capture strobe
  input wire logic sample_take,
  // Bench choices
  input wire dcd_iq_t [NUM_LANE-1:0] lane_word,
  input wire logic [NUM_LANE-1:0] lane_up,
  // Lanes into the device
  output dcd_iq_t [NUM_LANE-1:0] phys_lane,
  output logic [NUM_LANE-1:0] lane_valid
);
  // Complex pairs on every lane; off a capture cycle the inverse shows,
  // so a wrongly timed capture sees garbage
  assign phys_lane = sample_take ? lane_word : ~lane_word;
  assign lane_valid = lane_up;
endmodule : dcd_lane_src
`default_nettype wire

//--- tb/tb_top.sv
// Bench: serial register access, capture timing, channel sums and mute
`timescale 1ns/1ps
`default_nettype none
module tb_top import dcd_pkg::*;;
  // Inputs, all set at time zero
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic spi_sclk = 1'b0;
  logic spi_csb = 1'b1;
  logic spi_sdi = 1'b0;
  logic sysref = 1'b0;
  dcd_iq_t [NUM_LANE-1:0] lane_word = '0;
  logic [NUM_LANE-1:0] lane_up = 8'hA5;
  // Outputs
  dcd_iq_t [NUM_LANE-1:0] phys_lane;
  logic [NUM_LANE-1:0] lane_valid;
  logic spi_sdo;
  logic spi_sdo_oe;
  logic sample_take;
  logic signed [15:0] dac0;
  logic signed [15:0] dac1;
  logic [1:0] pa_mute;
  // Score, scratch and tables; datapath cases are {enable, switch mode, live outputs}
  int fails = 0;
  int total_checks = 0;
  int n;
  logic [7:0] rd;
  int cf[6] = '{1, 2, 3, 4, 6, 8};
  int mf[6] = '{1, 2, 4, 6, 8, 12};
  logic [15:0] dp[9] = '{16'h0000, 16'h0101, 16'h0300, 16'h0802, 16'h0401, 16'h0410, 16'h0123, 16'h0421, 16'h0133};

  // 250 MHz clock
  always #2 clk_sys = ~clk_sys;

  dcd_top dcd_top_i (
    .clk_sys, .srst, .spi_sclk, .spi_csb, .spi_sdi, .spi_sdo, .spi_sdo_oe, .phys_lane, .lane_valid,
    .sample_take, .sysref, .dac0, .dac1, .pa_mute
  );
  dcd_lane_src dcd_lane_src_i (.sample_take, .lane_word, .lane_up, .phys_lane, .lane_valid);

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : close_out

  // Inputs move 1 ns after the edge so the design samples settled values
  task automatic tick(input int c);
    repeat (c) @(posedge clk_sys);
    #1;
  endtask : tick

  // With live set, any known value other than exp passes
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input logic live);
    total_checks++;
    if (live ? (^got === 1'bx || got === exp) : got !== exp) begin
      fails++;
      $display("wrong value at %0t: got %h ref %h", $time, got, exp);
    end
  endtask : chk

  // One frame, MSB first, sclk near 18 MHz; read bits caught at sclk rise
  task automatic spi(input logic [23:0] frm);
    spi_csb = 1'b0;
    for (int b = 23; b >= 0; b--) begin
      spi_sdi = frm[b];
      tick(7);
      spi_sclk = 1'b1;
      rd[b % 8] = spi_sdo;
      tick(7);
      spi_sclk = 1'b0;
    end
    tick(4);
    spi_csb = 1'b1;
    tick(8);
  endtask : spi

  task automatic wr(input logic [14:0] a, input logic [7:0] d);
    spi({1'b0, a, d});
  endtask : wr

  task automatic rc(input logic [14:0] a, input logic [7:0] e);
    spi({1'b1, a, 8'h00});
    chk({8'h00, rd}, {8'h00, e}, 1'b0);
  endtask : rc

  // Bounded wait on sample_take (sel 0) or a mute flag; a hang ends the run
  task automatic wait_on(input int sel, input logic lvl);
    for (int c = 0; (sel == 0 ? sample_take : pa_mute[sel-1]) !== lvl; c++) begin
      if (c > 400) begin
        fails++;
        $display("wrong value at %0t: wait ran out", $time);
        close_out();
      end
      tick(1);
    end
  endtask : wait_on

  // Cycles from one capture strobe to the next
  task automatic gap(output int c);
    wait_on(0, 1'b1);
    tick(1);
    for (c = 1; sample_take !== 1'b1 && c < 120; c++)
      tick(1);
    if (c >= 120) begin
      fails++;
      $display("wrong value at %0t: capture strobe lost", $time);
      close_out();
    end
  endtask : gap

  initial begin
    tick(6);
    lane_word[0] = {16'h1234, 16'h0456};
    lane_word[1] = {16'hEDCC, 16'hFBAA};
    lane_word[2] = {16'h2000, 16'h0000};
    lane_word[4] = {16'h1234, 16'h0456};
    srst = 1'b0;
    tick(3);
    // Reset values, unmapped address, link paging
    rc(ADDR_CH_GAIN + 15'h001, 8'h40);
    rc(ADDR_PA_THR, 8'h7F);
    rc(15'h0100, 8'h00);
    rc(ADDR_LANE_STAT, 8'h05);
    wr(ADDR_LINK_PAGE, 8'h04);
    rc(ADDR_LINK_PAGE, 8'h04);
    rc(ADDR_LANE_STAT, 8'h0A);
    wr(ADDR_LINK_PAGE, 8'h00);
    // Every legal code pair sets the capture period; the first gap after a change is discarded
    for (int a = 0; a < 6; a++) begin
      wr(ADDR_CH_INTERP, 8'(a));
      for (int m = 0; m < 6; m++) begin
        wr(ADDR_MAIN_INTERP, 8'(m));
        gap(n);
        gap(n);
        chk(16'(n), 16'(cf[a] * mf[m]), 1'b0);
      end
    end
    // Illegal code halts capture and raises the error flag
    wr(ADDR_CH_INTERP, 8'h06);
    n = 0;
    repeat (150) begin
      tick(1);
      if (sample_take !== 1'b0) n++;
    end
    chk(16'(n), 16'h0000, 1'b0);
    rc(ADDR_STATUS, 8'h08);
    wr(ADDR_CH_INTERP, 8'h00);
    wr(ADDR_MAIN_INTERP, 8'h00);
    // Channel sums, bypass, group routing and switch modes
    for (int k = 0; k < 9; k++) begin
      wr(ADDR_CHAN_EN, dp[k][15:8]);
      wr(ADDR_NCO_CTRL, {2'b00, dp[k][5:4], 4'h0});
      tick(20);
      chk(16'(dac0), 16'h0000, dp[k][0]);
      chk(16'(dac1), 16'h0000, dp[k][1]);
    end
    // Lane 1 remapped from physical lane 0 undoes the cancellation
    wr(ADDR_NCO_CTRL, 8'h00);
    wr(ADDR_CHAN_EN, 8'h03);
    wr(ADDR_XBAR, 8'h00);
    tick(20);
    chk(16'(dac0), 16'h0000, 1'b1);
    wr(ADDR_XBAR, 8'h10);
    // Zero gain silences an interpolating channel; bypass skips the gain stage
    wr(ADDR_CHAN_EN, 8'h01);
    wr(ADDR_CH_GAIN, 8'h00);
    wr(ADDR_CH_GAIN + 15'h001, 8'h00);
    tick(20);
    chk(16'(dac0), 16'h0000, 1'b1);
    wr(ADDR_CH_INTERP, 8'h01);
    tick(20);
    chk(16'(dac0), 16'h0000, 1'b0);
    wr(ADDR_CH_INTERP, 8'h00);
    // Protection trips both paths, mutes, then releases
    wr(ADDR_CHAN_EN, 8'h09);
    wr(ADDR_PA_THR, 8'h00);
    wr(ADDR_PA_CTRL, 8'h03);
    wait_on(1, 1'b1);
    wait_on(2, 1'b1);
    tick(140);
    chk(16'(dac0), 16'h0000, 1'b0);
    chk(16'(dac1), 16'h0000, 1'b0);
    wr(ADDR_PA_CTRL, 8'h00);
    wait_on(1, 1'b0);
    tick(150);
    chk(16'(dac0), 16'h0000, 1'b1);
    // Alignment pulse is latched until cleared
    sysref = 1'b1;
    tick(3);
    sysref = 1'b0;
    tick(10);
    rc(ADDR_STATUS, 8'h04);
    wr(ADDR_STATUS, 8'h04);
    rc(ADDR_STATUS, 8'h00);
    // Shared register level reaches both converters and the calibration tone reaches dac0 with every channel off
    wr(ADDR_CHAN_EN, 8'h00);
    tick(20);
    chk(16'(dac0), 16'h0000, 1'b0);
    wr(ADDR_DDS_LVL + 15'h001, 8'h10);
    wr(ADDR_NCO_CTRL, 8'h06);
    tick(20);
    chk(16'(dac0), 16'h0000, 1'b1);
    chk(16'(dac1), 16'h0000, 1'b1);
    wr(ADDR_NCO_CTRL, 8'h08);
    tick(20);
    chk(16'(dac0), 16'h0000, 1'b1);
    close_out();
  end
endmodule : tb_top
`default_nettype wire
